//--- design/pcb_pkg.sv
// package: register map, field layout and reset values of the loop profile bank
package pcb_pkg;

	// ----------------------------------------------------------------
	// register indexes (one aligned 32-bit word each, byte address is index times four)
	// ----------------------------------------------------------------
	localparam logic [7:0] PCB_OFF_SET0_W0   = 8'h28;
	localparam logic [7:0] PCB_OFF_SET0_W1   = 8'h29;
	localparam logic [7:0] PCB_OFF_SET0_W2   = 8'h2a;
	localparam logic [7:0] PCB_OFF_SET0_W3   = 8'h2b;
	localparam logic [7:0] PCB_OFF_SET1_W0   = 8'h2c;
	localparam logic [7:0] PCB_OFF_SET1_W1   = 8'h2d;
	localparam logic [7:0] PCB_OFF_SET1_W2   = 8'h2e;
	localparam logic [7:0] PCB_OFF_SET1_W3   = 8'h2f;
	localparam logic [7:0] PCB_OFF_SPREAD_A  = 8'h30;
	localparam logic [7:0] PCB_OFF_SPREAD_B  = 8'h31;
	localparam logic [7:0] PCB_OFF_SPREAD_C  = 8'h32;
	localparam logic [7:0] PCB_OFF_FSEL      = 8'h33;
	localparam logic [7:0] PCB_OFF_DIR       = 8'h36;
	localparam logic [7:0] PCB_OFF_STATUS    = 8'h3c;

	// byte addresses are index times four
	localparam int         PCB_ADDR_SHIFT    = 2;
	localparam int         PCB_NUM_BYTES     = 12;
	localparam logic [7:0] PCB_FIRST_OFF     = 8'h28;

	// ----------------------------------------------------------------
	// reset values of the twelve bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] PCB_RST_W0        = 8'h00;
	localparam logic [7:0] PCB_RST_W1        = 8'h40;
	localparam logic [7:0] PCB_RST_W2        = 8'h02;
	localparam logic [7:0] PCB_RST_W3        = 8'h08;
	localparam logic [7:0] PCB_RST_SPREAD    = 8'h00;
	localparam logic [7:0] PCB_RST_FSEL      = 8'h00;
	localparam logic       PCB_RST_DIR       = 1'b0;

	// ----------------------------------------------------------------
	// field positions inside a 32-bit parameter word
	// ----------------------------------------------------------------
	localparam int PCB_N_MSB     = 31;
	localparam int PCB_N_LSB     = 20;
	localparam int PCB_R_MSB     = 19;
	localparam int PCB_R_LSB     = 11;
	localparam int PCB_Q_MSB     = 10;
	localparam int PCB_Q_LSB     = 5;
	localparam int PCB_P_MSB     = 4;
	localparam int PCB_P_LSB     = 2;
	localparam int PCB_BAND_MSB  = 1;
	localparam int PCB_BAND_LSB  = 0;
	localparam int PCB_DIR_BIT   = 7;
	localparam int PCB_SSC_W     = 3;
	localparam int PCB_SETTINGS  = 8;

	// ----------------------------------------------------------------
	// oscillator band and spread encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PCB_BAND_BELOW_125 = 2'h0,
		PCB_BAND_125_150   = 2'h1,
		PCB_BAND_150_175   = 2'h2,
		PCB_BAND_ABOVE_175 = 2'h3
	} pcb_band_e;

	typedef enum logic
	{
		PCB_DIR_DOWN   = 1'b0,
		PCB_DIR_CENTRE = 1'b1
	} pcb_dir_e;

	// spread in quarter-percent steps
	localparam logic [3:0] PCB_SSC_QP_0 = 4'h0;
	localparam logic [3:0] PCB_SSC_QP_1 = 4'h1;
	localparam logic [3:0] PCB_SSC_QP_2 = 4'h2;
	localparam logic [3:0] PCB_SSC_QP_3 = 4'h3;
	localparam logic [3:0] PCB_SSC_QP_4 = 4'h4;
	localparam logic [3:0] PCB_SSC_QP_5 = 4'h5;
	localparam logic [3:0] PCB_SSC_QP_6 = 4'h6;
	localparam logic [3:0] PCB_SSC_QP_7 = 4'h8;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [11:0] feedback_count;
		logic [8:0]  fraction_r;
		logic [5:0]  fraction_q;
		logic [2:0]  prescale_p;
		pcb_band_e   osc_band;
	} pcb_param_set_s;

	typedef struct packed
	{
		logic       modulation_on;
		pcb_dir_e   direction;
		logic [3:0] quarter_percent;
		logic [2:0] amount_code;
	} pcb_spread_s;

	typedef struct packed
	{
		logic [1:0]  htrans;
		logic [31:0] haddr;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hsel;
	} pcb_ahb_addr_s;

endpackage

//--- design/pcb_profile_bank.sv
// loop profile bank: AHB-Lite registers, pin-selected spread and frequency set
`timescale 1ns/1ps

// How it works
// R1: two 30-bit N/R/Q/P sets, four bytes each
// R2: each set carries 2-bit oscillator band code
// R3: host keeps Q, P, R, N in range
// R4: eight 3-bit spread codes packed from 30h
// R5: spread code decodes off or 0.25..2.0 percent
// R6: eight set selectors in byte at 33h
// R7: direction bit picks down or centre spread
// R8: three select pins index the active setting
// R9: host avoids writes above 40h
// R10: configuration bytes travel most significant byte first
// R11: pin change applies new entry without writes
module pcb_profile_bank
	import pcb_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// setting select pins
	input  wire logic        setting_select_pin_lsb_i,
	input  wire logic        setting_select_pin_mid_i,
	input  wire logic        setting_select_pin_msb_i,
	// active loop profile
	output pcb_param_set_s   active_set_o,
	output pcb_spread_s      active_spread_o,
	output logic             third_loop_freq_set_choice_o,
	output logic      [2:0]  active_setting_o
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0]      cfg_byte [PCB_NUM_BYTES];
	logic            third_loop_spread_direction;
	logic [2:0]      pin_meta;
	logic [2:0]      pin_sync;
	pcb_ahb_addr_s   dphase;
	logic            wr_pend;
	logic [31:0]     next_rdata;
	logic [23:0]     spread_word;
	logic [2:0]      third_loop_spread_amount;
	pcb_spread_s     dec_spread;
	pcb_param_set_s  sel_set;

	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_bank(input logic [31:0] addr);
		logic [7:0] off;
		off = addr[9:2];
		is_bank = (addr[31:10] == 22'h00_0000) && (addr[1:0] == 2'h0) &&
			(off >= PCB_OFF_SET0_W0) && (off <= PCB_OFF_FSEL);
	endfunction

	function automatic logic [3:0] bank_index(input logic [31:0] addr);
		logic [7:0] rel;
		rel = addr[9:2] - PCB_FIRST_OFF;
		bank_index = rel[3:0];
	endfunction

	// one aligned word per byte register: byte address is the index times four
	function automatic logic [31:0] byte_addr(input logic [7:0] off);
		byte_addr = 32'({22'h00_0000, off}) << PCB_ADDR_SHIFT;
	endfunction

	// assemble a 32-bit parameter word from four bytes, first byte on top
	function automatic pcb_param_set_s param_word(input logic [3:0] base);
		logic [31:0] w;
		w = {cfg_byte[base], cfg_byte[base + 4'h1], cfg_byte[base + 4'h2],
			cfg_byte[base + 4'h3]}; // R10
		param_word = pcb_param_set_s'({w[PCB_N_MSB:PCB_N_LSB], w[PCB_R_MSB:PCB_R_LSB],
			w[PCB_Q_MSB:PCB_Q_LSB], w[PCB_P_MSB:PCB_P_LSB], w[PCB_BAND_MSB:PCB_BAND_LSB]});
	endfunction

	// ----------------------------------------------------------------
	// bus address phase capture
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dphase  <= '0;
			wr_pend <= 1'b0;
		end
		else if (hready_i)
		begin
			dphase.hsel   <= hsel_i;
			dphase.haddr  <= haddr_i;
			dphase.htrans <= htrans_i;
			dphase.hwrite <= hwrite_i;
			dphase.hsize  <= hsize_i;
			wr_pend       <= hsel_i && htrans_i[1] && hwrite_i;
		end
		else
		begin
			wr_pend <= 1'b0;
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register writes: data phase, low byte lane only
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PCB_NUM_BYTES; gi++)
		begin : g_byte
			localparam logic [7:0] RST_VAL =
				(gi < 8)  ? ((gi % 4 == 0) ? PCB_RST_W0 :
				             (gi % 4 == 1) ? PCB_RST_W1 :
				             (gi % 4 == 2) ? PCB_RST_W2 : PCB_RST_W3) :
				(gi < 11) ? PCB_RST_SPREAD : PCB_RST_FSEL;
			always_ff @(posedge sys_clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
					cfg_byte[gi] <= RST_VAL;
				// locations outside the bank, including above 40h, are ignored
				else if (wr_pend && is_bank(dphase.haddr) &&
					bank_index(dphase.haddr) == 4'(gi)) // R1 R4 R6 R9
					cfg_byte[gi] <= hwdata_i[7:0];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			third_loop_spread_direction <= PCB_RST_DIR;
		else if (wr_pend && dphase.haddr == byte_addr(PCB_OFF_DIR))
			third_loop_spread_direction <= hwdata_i[PCB_DIR_BIT]; // R7
	end

	// ----------------------------------------------------------------
	// read mux, registered so hrdata is a flip-flop; valid next cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (hsel_i && htrans_i[1] && !hwrite_i)
		begin
			if (is_bank(haddr_i))
				next_rdata = {24'h00_0000, cfg_byte[bank_index(haddr_i)]};
			else if (haddr_i == byte_addr(PCB_OFF_DIR))
				next_rdata = {24'h00_0000, third_loop_spread_direction, 7'h00};
			else if (haddr_i == byte_addr(PCB_OFF_STATUS))
				next_rdata = {22'h00_0000, pin_sync, 1'b0, sel_set.osc_band,
					third_loop_spread_amount, third_loop_freq_set_choice_o};
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			hrdata_o <= 32'h0000_0000;
		else if (hready_i)
			hrdata_o <= next_rdata;
	end

	// ----------------------------------------------------------------
	// select pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end
		else
		begin
			pin_meta <= {setting_select_pin_msb_i, setting_select_pin_mid_i,
				setting_select_pin_lsb_i};
			pin_sync <= pin_meta; // R8
		end
	end

	// ----------------------------------------------------------------
	// active entry lookup
	// ----------------------------------------------------------------
	// setting 7 sits in the top three bits of 30h, setting 0 at the bottom of 32h
	assign spread_word = {cfg_byte[8], cfg_byte[9], cfg_byte[10]}; // R4
	assign third_loop_spread_amount =
		spread_word[pin_sync * PCB_SSC_W +: PCB_SSC_W]; // R8 R11

	assign sel_set = cfg_byte[11][pin_sync] ? param_word(4'h4) : param_word(4'h0); // R6 R1 R2

	pcb_spread_decode u_spread_decode
	(
		.code_i   (third_loop_spread_amount),
		.dir_i    (pcb_dir_e'(third_loop_spread_direction)),
		.spread_o (dec_spread)
	); // R5

	// outputs follow the pins continuously, no write needed
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			active_set_o                 <= '0;
			active_spread_o              <= '0;
			third_loop_freq_set_choice_o <= 1'b0;
			active_setting_o             <= 3'h0;
		end
		else
		begin
			active_set_o                 <= sel_set; // R11
			active_spread_o              <= dec_spread; // R5 R7
			third_loop_freq_set_choice_o <= cfg_byte[11][pin_sync]; // R6
			active_setting_o             <= pin_sync;
		end
	end

endmodule

//--- design/pcb_spread_decode.sv
// spread code decoder for the third loop
`timescale 1ns/1ps

module pcb_spread_decode
	import pcb_pkg::*;
(
	// code in
	input  wire logic [2:0]  code_i,
	input  wire pcb_dir_e    dir_i,
	// decoded spread
	output pcb_spread_s      spread_o
);

	logic [3:0] quarter_percent;

	always_comb
	begin
		case (code_i)
			3'h0:    quarter_percent = PCB_SSC_QP_0;
			3'h1:    quarter_percent = PCB_SSC_QP_1;
			3'h2:    quarter_percent = PCB_SSC_QP_2;
			3'h3:    quarter_percent = PCB_SSC_QP_3;
			3'h4:    quarter_percent = PCB_SSC_QP_4;
			3'h5:    quarter_percent = PCB_SSC_QP_5;
			3'h6:    quarter_percent = PCB_SSC_QP_6;
			default: quarter_percent = PCB_SSC_QP_7;
		endcase
	end

	// code zero stops modulation; the top code jumps to 2.0 percent
	assign spread_o.modulation_on   = (code_i != 3'h0);
	assign spread_o.direction       = dir_i;
	assign spread_o.quarter_percent = quarter_percent;
	assign spread_o.amount_code     = code_i;

endmodule

//--- verification/pcb_host_model.sv
// host model: AHB-Lite master for the profile bank and setting select pins
`timescale 1ns/1ps

module pcb_host_model
(
	// clock
	input  wire logic        sys_clk_i,
	// AHB-Lite master
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_i,
	output logic      [1:0]  htrans_o,
	output logic      [31:0] haddr_o,
	output logic             hwrite_o,
	output logic      [2:0]  hsize_o,
	output logic      [31:0] hwdata_o,
	// setting select pins {msb,mid,lsb}
	output logic      [2:0]  pins_o
);
	initial
	begin
		htrans_o = 2'h0;
		haddr_o  = 32'h0000_0000;
		hwrite_o = 1'b0;
		hsize_o  = 3'h2;
		hwdata_o = 32'h0000_0000;
		pins_o   = 3'h0;
	end

	// bounded wait for hready; a hang ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (hready_i !== 1'b1 && n < 64);
		if (hready_i !== 1'b1)
			tb.host_hang();
	endtask

	// one single word transfer; idx is the register index, address is four times it
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge sys_clk_i);
		htrans_o <= 2'h2;
		haddr_o  <= {22'h0, idx, 2'b00};
		hwrite_o <= wr;
		hsize_o  <= 3'h2;
		wait_ready();
		htrans_o <= 2'h0;
		hwdata_o <= wd;
		wait_ready();
		rd = hrdata_i;
	endtask

	task automatic set_pins(input logic [2:0] v);
		@(posedge sys_clk_i);
		pins_o <= v;
	endtask
endmodule

//--- verification/pcb_profile_bank_chk.sv
// checker: bus answer, pin synchronizer and spread decode of the profile bank
`timescale 1ns/1ps

module pcb_profile_bank_chk
	import pcb_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_o,
	input  wire logic        hreadyout_o,
	input  wire logic        hresp_o,
	input  wire logic        setting_select_pin_lsb_i,
	input  wire logic        setting_select_pin_mid_i,
	input  wire logic        setting_select_pin_msb_i,
	input  wire pcb_spread_s active_spread_o,
	input  wire logic        third_loop_freq_set_choice_o,
	input  wire logic [2:0]  active_setting_o
);
	logic [2:0] pins;
	logic       req;
	logic [7:0] idx;
	assign pins = {setting_select_pin_msb_i, setting_select_pin_mid_i, setting_select_pin_lsb_i};
	assign req  = hsel_i && htrans_i[1] && hready_i;
	assign idx  = haddr_i[9:2];

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	ready_always_a: assert property (hreadyout_o == 1'b1) else $error("hreadyout low");
	resp_okay_a: assert property (hresp_o == 1'b0) else $error("error response");
	rst_clear_a: assert property ($rose(rst_b_i) |-> hrdata_o == 32'h0 && active_setting_o == 3'h0)
		else $error("outputs not cleared by reset");
	pin_track_a: assert property ($stable(pins)[*5] |-> active_setting_o == pins)
		else $error("active setting does not follow pins");
	sync_delay_a: assert property ($stable(pins)[*3] ##1 $changed(pins) |=> $stable(active_setting_o))
		else $error("pin change passed the synchronizer too early");
	spread_on_a: assert property (active_spread_o.modulation_on == (active_spread_o.amount_code != 3'h0))
		else $error("modulation flag wrong");
	spread_pct_a: assert property (active_spread_o.quarter_percent ==
		((active_spread_o.amount_code == 3'h7) ? 4'h8 : {1'b0, active_spread_o.amount_code}))
		else $error("spread amount decode wrong");
	entry_hold_a: assert property ((!(req && hwrite_i) && $stable(pins))[*5]
		|=> $stable(active_spread_o) && $stable(third_loop_freq_set_choice_o))
		else $error("active entry moved without cause");
	unmapped_zero_a: assert property (req && !hwrite_i && haddr_i[31:10] == 22'h0 && (idx < 8'h28
		|| idx > 8'h3c) |=> hrdata_o == 32'h0) else $error("unmapped read not zero");

	cover property (req && hwrite_i);
	cover property ($changed(pins));
	cover property (active_spread_o.modulation_on && active_spread_o.direction == PCB_DIR_CENTRE);
endmodule

bind pcb_profile_bank pcb_profile_bank_chk pcb_profile_bank_chk_inst (.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .setting_select_pin_lsb_i(setting_select_pin_lsb_i),
	.setting_select_pin_mid_i(setting_select_pin_mid_i),
	.setting_select_pin_msb_i(setting_select_pin_msb_i), .active_spread_o(active_spread_o),
	.third_loop_freq_set_choice_o(third_loop_freq_set_choice_o),
	.active_setting_o(active_setting_o));

//--- verification/tb.sv
// testbench: register access and pin-selected profile of the bank
`timescale 1ns/1ps

module tb;
	import pcb_pkg::*;
	logic           sys_clk_i = 1'b0;
	logic           rst_b_i = 1'b0;
	logic [1:0]     htrans;
	logic [31:0]    haddr, hwdata, hrdata, rd, w1;
	logic           hwrite, hready;
	logic [2:0]     pins, asel, hsize;
	logic [23:0]    sc;
	pcb_param_set_s aset;
	pcb_spread_s    aspr;
	logic           choice;
	int             num_errors = 0;
	int             total_checks = 0;
	logic [7:0]     rst_tab [12] = '{PCB_RST_W0, PCB_RST_W1, PCB_RST_W2, PCB_RST_W3, PCB_RST_W0,
		PCB_RST_W1, PCB_RST_W2, PCB_RST_W3, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [3:0]     qp [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};

	always #2.5 sys_clk_i = ~sys_clk_i;

	pcb_host_model pcb_host_model_inst (.sys_clk_i(sys_clk_i), .hready_i(hready),
		.hrdata_i(hrdata), .htrans_o(htrans), .haddr_o(haddr), .hwrite_o(hwrite), .hsize_o(hsize),
		.hwdata_o(hwdata), .pins_o(pins));

	pcb_profile_bank pcb_profile_bank_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(), .setting_select_pin_lsb_i(pins[0]), .setting_select_pin_mid_i(pins[1]),
		.setting_select_pin_msb_i(pins[2]), .active_set_o(aset), .active_spread_o(aspr),
		.third_loop_freq_set_choice_o(choice), .active_setting_o(asel));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic host_hang();
		num_errors++;
		test_done();
	endtask

	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			pcb_host_model_inst.xfer(1'b0, PCB_FIRST_OFF + 8'(i), 32'h0, rd);
			chk(rd, {24'h0, rst_tab[i]});
		end
		chk(aset, {PCB_RST_W0, PCB_RST_W1, PCB_RST_W2, PCB_RST_W3});
		// boundary values of the host's legal ranges, band code 11
		w1 = {12'habc, 9'h1ff, 6'h3f, 3'h7, 2'h3};
		for (int k = 0; k < 8; k++)
			sc[3*k +: 3] = 3'(k);
		for (int i = 0; i < 4; i++)
			pcb_host_model_inst.xfer(1'b1, PCB_OFF_SET1_W0 + 8'(i), {24'h0, w1[31-8*i -: 8]}, rd);
		for (int i = 0; i < 3; i++)
			pcb_host_model_inst.xfer(1'b1, PCB_OFF_SPREAD_A + 8'(i), {24'h0, sc[23-8*i -: 8]}, rd);
		pcb_host_model_inst.xfer(1'b1, PCB_OFF_FSEL, 32'h0000_00aa, rd);
		pcb_host_model_inst.xfer(1'b1, PCB_OFF_DIR, 32'h0000_0080, rd);
		for (int i = 0; i < 4; i++)
		begin
			pcb_host_model_inst.xfer(1'b0, PCB_OFF_SET1_W0 + 8'(i), 32'h0, rd);
			chk(rd, {24'h0, w1[31-8*i -: 8]});
		end
		// every setting, pins alone move the active entry
		for (int k = 0; k < 8; k++)
		begin
			pcb_host_model_inst.set_pins(3'(k));
			repeat (5) @(posedge sys_clk_i);
			chk({29'h0, asel}, 32'(k));
			chk({23'h0, aspr}, {23'h0, k != 0, 1'b1, qp[k], 3'(k)});
			chk({31'h0, choice}, {31'h0, k[0]});
			chk(aset, k[0] ? w1 : {PCB_RST_W0, PCB_RST_W1, PCB_RST_W2, PCB_RST_W3});
		end
		// pins still at setting 7: choice 1, code 7, band 3 of set 1
		pcb_host_model_inst.xfer(1'b0, PCB_OFF_STATUS, 32'h0, rd);
		chk(rd, 32'h0000_03bf);
		pcb_host_model_inst.xfer(1'b1, PCB_OFF_DIR, 32'h0000_0000, rd);
		repeat (5) @(posedge sys_clk_i);
		chk({31'h0, aspr.direction}, 32'h0000_0000);
		pcb_host_model_inst.xfer(1'b1, 8'h3e, 32'h0000_00ff, rd);
		pcb_host_model_inst.xfer(1'b0, 8'h3e, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		test_done();
	end
endmodule
